//--- verilog/lcis_map.vh
// Register map, widths and input indices of the cell input selection stage
`ifndef LCIS_MAP_VH
`define LCIS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Sizes
`define LCIS_SEL_W          5
`define LCIS_NUM_IN         32
`define LCIS_NUM_MUX        4
`define LCIS_NUM_PIN        4
`define LCIS_NUM_SYNC       7
`define LCIS_SEL_RST        5'h0

////////////////////////////////////////////////////////////////////////////////
// Register offsets, byte addresses
`define LCIS_OFS_MSB        7
`define LCIS_OFS_W          8
`define LCIS_OFS_SEL0       8'h00
`define LCIS_OFS_SEL1       8'h04
`define LCIS_OFS_SEL2       8'h08
`define LCIS_OFS_SEL3       8'h0C
`define LCIS_OFS_STATUS     8'h10
`define LCIS_OFS_IDX_HI     3
`define LCIS_OFS_IDX_LO     2
`define LCIS_SEL_SPAN_HI    8'h0C

////////////////////////////////////////////////////////////////////////////////
// Bus constants
`define LCIS_HTRANS_ACTIVE  1
`define LCIS_HRESP_OKAY     1'b0
`define LCIS_RDATA_ZERO     32'h0000_0000
`define LCIS_STATUS_PAD     28'h000_0000
`define LCIS_SEL_PAD        27'h000_0000

////////////////////////////////////////////////////////////////////////////////
// Candidate input indices
`define LCIS_IDX_PIN0       0
`define LCIS_IDX_PIN3       3
`define LCIS_IDX_CELL1      4
`define LCIS_IDX_CELL4      7
`define LCIS_IDX_CMP1       8
`define LCIS_IDX_CMP2       9
`define LCIS_IDX_CGEN_A     10
`define LCIS_IDX_CGEN_B     11
`define LCIS_IDX_CCP1       12
`define LCIS_IDX_CCP2       13
`define LCIS_IDX_PWM3       14
`define LCIS_IDX_PWM4       15
`define LCIS_IDX_SSP_CLK    16
`define LCIS_IDX_SSP_DATA   17
`define LCIS_IDX_NCO        18
`define LCIS_IDX_ZCD        19
`define LCIS_IDX_ASP_TX     20
`define LCIS_IDX_ASP_DATA   21
`define LCIS_IDX_TMR4       22
`define LCIS_IDX_TMR6       23
`define LCIS_IDX_TMR0       24
`define LCIS_IDX_TMR1       25
`define LCIS_IDX_TMR2       26
`define LCIS_IDX_PCHG       27
`define LCIS_IDX_RC_CLK     28
`define LCIS_IDX_LF_OSC     29
`define LCIS_IDX_HF_OSC     30
`define LCIS_IDX_SYS_CLK    31

`endif

//--- verilog/lcis_sync2.v
// Two flip-flop synchroniser for asynchronous levels
module lcis_sync2
#(
    parameter W = 1
)
(
    // Clock and reset
    input  wire         clk_i,
    input  wire         reset_i,
    // Data
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);

    reg [W-1:0] meta;
    reg [W-1:0] stable;

    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta   <= {W{1'b0}};
            stable <= {W{1'b0}};
        end
        else
        begin
            meta   <= d_i;
            stable <= meta;
        end
    end

    assign q_o = stable;

endmodule // lcis_sync2

//--- verilog/lcis_mux32.v
// One registered 32-way input multiplexer
`include "lcis_map.vh"

module lcis_mux32
(
    // Clock and reset
    input  wire                     clk_i,
    input  wire                     reset_i,
    // Candidates and select
    input  wire [`LCIS_NUM_IN-1:0]  cand_i,
    input  wire [`LCIS_SEL_W-1:0]   sel_i,
    // Selected bit
    output reg                      out_o
);

    always @(posedge clk_i)
    begin
        if (reset_i)
            out_o <= 1'b0;
        else
            out_o <= cand_i[sel_i];
    end

endmodule // lcis_mux32

//--- verilog/lcis_top.v
// Input selection stage of a configurable logic cell with AHB-Lite registers
//
// What this block does
// - Selection is the first of four stages: selection, gating, function, polarity.
// - Software may rewrite selects any time; new selects apply without halt.
// - Thirty-two candidates feed four independent 32-way multiplexers.
// - Each multiplexer has a 5-bit select; value equals routed input index.
// - Each select lives in its own register, four registers per cell.
// - Selects reset to code 0; software programs all four first.
// - Codes 0 to 3 route the four remapped cell input pins.
// - Codes 4 to 7 route outputs of cells 1 to 4.
// - Codes 8 to 15: comparators, generator A/B, capture/compare, pulse-width 3/4.
// - Codes 16 to 19: serial port clock, data, oscillator, zero-cross outputs.
// - Codes 20 to 27: async serial lines, timer events, pin-change flag pulse.
// - Codes 28 to 31: RC clock, low and high oscillators, system clock.
`include "lcis_map.vh"

module lcis_top
(
    // Clock and reset
    input  wire                         SYS_CLK_I,
    input  wire                         RESET_I,
    // AHB-Lite slave
    input  wire                         HSEL_I,
    input  wire [31:0]                  HADDR_I,
    input  wire [1:0]                   HTRANS_I,
    input  wire                         HWRITE_I,
    input  wire [2:0]                   HSIZE_I,
    input  wire [31:0]                  HWDATA_I,
    input  wire                         HREADY_I,
    output reg  [31:0]                  HRDATA_O,
    output reg                          HREADYOUT_O,
    output reg                          HRESP_O,
    // Remapped cell input pins
    input  wire [`LCIS_NUM_PIN-1:0]     CELL_PIN_I,
    // Outputs of logic cells 1 to 4
    input  wire [`LCIS_NUM_MUX-1:0]     LOGIC_CELL_OUT_I,
    // On-chip peripheral signals
    input  wire [1:0]                   COMPARATOR_SYNC_OUT_I,
    input  wire                         COMP_GEN_OUT_A_I,
    input  wire                         COMP_GEN_OUT_B_I,
    input  wire [1:0]                   CAPTURE_COMPARE_OUT_I,
    input  wire [1:0]                   PULSE_WIDTH_OUT_I,
    input  wire                         SYNC_SERIAL_CLK_I,
    input  wire                         SYNC_SERIAL_DATA_I,
    input  wire                         NUMERIC_OSC_OUTPUT_I,
    input  wire                         ZERO_CROSS_OUTPUT_I,
    input  wire                         ASYNC_SERIAL_TX_I,
    input  wire                         ASYNC_SERIAL_DATA_I,
    input  wire                         TIMER4_MATCH_I,
    input  wire                         TIMER6_MATCH_I,
    input  wire                         TIMER0_OVERFLOW_I,
    input  wire                         TIMER1_OVERFLOW_I,
    input  wire                         TIMER2_MATCH_I,
    input  wire                         PIN_CHANGE_FLAG_I,
    // Foreign clock sources
    input  wire                         CONVERTER_RC_CLOCK_I,
    input  wire                         LF_INTERNAL_OSC_I,
    input  wire                         HF_INTERNAL_OSC_I,
    // Selected bits toward the gating stage
    output wire [`LCIS_NUM_MUX-1:0]     GATE_DATA_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg  [`LCIS_SEL_W-1:0]              sel_reg [0:`LCIS_NUM_MUX-1];
    reg                                 wr_pend;
    reg  [`LCIS_OFS_MSB:0]              wr_ofs;
    reg                                 sys_clk_ref;
    reg  [31:0]                         next_rdata;
    reg  [`LCIS_SEL_W-1:0]              rd_sel;
    wire [`LCIS_NUM_SYNC-1:0]           async_raw;
    wire [`LCIS_NUM_SYNC-1:0]           async_sync;
    wire [`LCIS_NUM_IN-1:0]             cand;
    wire [`LCIS_NUM_MUX-1:0]            mux_out;
    wire                                ahb_req;
    wire [`LCIS_OFS_MSB:0]              rd_ofs;
    wire                                wr_hit_sel;
    wire                                rd_hit_sel;
    wire [1:0]                          wr_idx;
    wire [1:0]                          rd_idx;
    integer                             i;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronise pins and foreign clocks
    assign async_raw = {HF_INTERNAL_OSC_I,
                        LF_INTERNAL_OSC_I,
                        CONVERTER_RC_CLOCK_I,
                        CELL_PIN_I};

    lcis_sync2
    #(
        .W                              (`LCIS_NUM_SYNC)
    )
    u_sync
    (
        .clk_i                          (SYS_CLK_I),
        .reset_i                        (RESET_I),
        .d_i                            (async_raw),
        .q_o                            (async_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // System clock reference, toggles each cycle
    always @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
            sys_clk_ref <= 1'b0;
        else
            sys_clk_ref <= ~sys_clk_ref;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Candidate vector
    assign cand[`LCIS_IDX_PIN3:`LCIS_IDX_PIN0]  = async_sync[`LCIS_NUM_PIN-1:0];
    assign cand[`LCIS_IDX_CELL4:`LCIS_IDX_CELL1] = LOGIC_CELL_OUT_I;
    assign cand[`LCIS_IDX_CMP1]     = COMPARATOR_SYNC_OUT_I[0];
    assign cand[`LCIS_IDX_CMP2]     = COMPARATOR_SYNC_OUT_I[1];
    assign cand[`LCIS_IDX_CGEN_A]   = COMP_GEN_OUT_A_I;
    assign cand[`LCIS_IDX_CGEN_B]   = COMP_GEN_OUT_B_I;
    assign cand[`LCIS_IDX_CCP1]     = CAPTURE_COMPARE_OUT_I[0];
    assign cand[`LCIS_IDX_CCP2]     = CAPTURE_COMPARE_OUT_I[1];
    assign cand[`LCIS_IDX_PWM3]     = PULSE_WIDTH_OUT_I[0];
    assign cand[`LCIS_IDX_PWM4]     = PULSE_WIDTH_OUT_I[1];
    assign cand[`LCIS_IDX_SSP_CLK]  = SYNC_SERIAL_CLK_I;
    assign cand[`LCIS_IDX_SSP_DATA] = SYNC_SERIAL_DATA_I;
    assign cand[`LCIS_IDX_NCO]      = NUMERIC_OSC_OUTPUT_I;
    assign cand[`LCIS_IDX_ZCD]      = ZERO_CROSS_OUTPUT_I;
    assign cand[`LCIS_IDX_ASP_TX]   = ASYNC_SERIAL_TX_I;
    assign cand[`LCIS_IDX_ASP_DATA] = ASYNC_SERIAL_DATA_I;
    assign cand[`LCIS_IDX_TMR4]     = TIMER4_MATCH_I;
    assign cand[`LCIS_IDX_TMR6]     = TIMER6_MATCH_I;
    assign cand[`LCIS_IDX_TMR0]     = TIMER0_OVERFLOW_I;
    assign cand[`LCIS_IDX_TMR1]     = TIMER1_OVERFLOW_I;
    assign cand[`LCIS_IDX_TMR2]     = TIMER2_MATCH_I;
    assign cand[`LCIS_IDX_PCHG]     = PIN_CHANGE_FLAG_I;
    assign cand[`LCIS_IDX_RC_CLK]   = async_sync[`LCIS_NUM_PIN];
    assign cand[`LCIS_IDX_LF_OSC]   = async_sync[`LCIS_NUM_PIN+1];
    assign cand[`LCIS_IDX_HF_OSC]   = async_sync[`LCIS_NUM_PIN+2];
    assign cand[`LCIS_IDX_SYS_CLK]  = sys_clk_ref;

    ////////////////////////////////////////////////////////////////////////////
    // Four independent multiplexers
    genvar g;
    generate
        for (g = 0; g < `LCIS_NUM_MUX; g = g + 1)
        begin : g_mux
            lcis_mux32 u_mux
            (
                .clk_i                  (SYS_CLK_I),
                .reset_i                (RESET_I),
                .cand_i                 (cand),
                .sel_i                  (sel_reg[g]),
                .out_o                  (mux_out[g])
            );
        end
    endgenerate

    // First stage output toward gating
    assign GATE_DATA_O = mux_out;

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture
    assign ahb_req    = HSEL_I & HREADY_I & HTRANS_I[`LCIS_HTRANS_ACTIVE];
    assign rd_ofs     = HADDR_I[`LCIS_OFS_MSB:0];
    assign wr_hit_sel = (wr_ofs <= `LCIS_SEL_SPAN_HI)
                        & (wr_ofs[`LCIS_OFS_IDX_LO-1:0] == 2'h0);
    assign rd_hit_sel = (rd_ofs <= `LCIS_SEL_SPAN_HI)
                        & (rd_ofs[`LCIS_OFS_IDX_LO-1:0] == 2'h0)
                        & (HADDR_I[31:`LCIS_OFS_W] == 24'h00_0000);
    assign wr_idx     = wr_ofs[`LCIS_OFS_IDX_HI:`LCIS_OFS_IDX_LO];
    assign rd_idx     = rd_ofs[`LCIS_OFS_IDX_HI:`LCIS_OFS_IDX_LO];

    always @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            wr_pend <= 1'b0;
            wr_ofs  <= {`LCIS_OFS_W{1'b0}};
        end
        else
        begin
            wr_pend <= ahb_req & HWRITE_I & (HADDR_I[31:`LCIS_OFS_W] == 24'h00_0000);
            wr_ofs  <= rd_ofs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Select registers, written in the data phase
    always @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            for (i = 0; i < `LCIS_NUM_MUX; i = i + 1)
                sel_reg[i] <= `LCIS_SEL_RST;
        end
        else if (wr_pend && wr_hit_sel)
        begin
            sel_reg[wr_idx] <= HWDATA_I[`LCIS_SEL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, forwarded from a write still in its data phase
    always @*
    begin
        rd_sel = sel_reg[rd_idx];
        if (wr_pend && wr_hit_sel && (wr_ofs == rd_ofs))
            rd_sel = HWDATA_I[`LCIS_SEL_W-1:0];
        next_rdata = `LCIS_RDATA_ZERO;
        if (rd_hit_sel)
            next_rdata = {`LCIS_SEL_PAD, rd_sel};
        else if (rd_ofs == `LCIS_OFS_STATUS
                 && HADDR_I[31:`LCIS_OFS_W] == 24'h00_0000)
            next_rdata = {`LCIS_STATUS_PAD, mux_out};
        else
            next_rdata = `LCIS_RDATA_ZERO;
    end

    always @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            HRDATA_O    <= `LCIS_RDATA_ZERO;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= `LCIS_HRESP_OKAY;
        end
        else
        begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= `LCIS_HRESP_OKAY;
            if (ahb_req && !HWRITE_I)
                HRDATA_O <= next_rdata;
            else
                HRDATA_O <= `LCIS_RDATA_ZERO;
        end
    end

endmodule // lcis_top

//--- testbench/lcis_props.sv
// Checker of bus answers and selected outputs of the input selection stage
module lcis_props
(
    // Clock and reset
    input wire logic        SYS_CLK_I,
    input wire logic        RESET_I,
    // Register bus
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    // Selected bits
    input wire logic [3:0]  GATE_DATA_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        wr_v;
    logic        rd_v;
    logic [31:0] ph_a;
    logic [4:0]  sh [4];
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the select registers
    always @(posedge SYS_CLK_I)
    begin
        if (RESET_I)
        begin
            wr_v <= 1'b0;
            rd_v <= 1'b0;
            sh   <= '{default: 5'h00};
        end
        else
        begin
            wr_v <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
            rd_v <= HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I;
            ph_a <= HADDR_I;
            if (wr_v && ph_a < 32'h0000_0010 && ph_a[1:0] == 2'h0)
                sh[ph_a[3:2]] <= HWDATA_I[4:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    chk_ready_high:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) HREADYOUT_O)
        else $error("ready low");
    chk_resp_okay:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) !HRESP_O)
        else $error("error response");
    chk_reset_clear:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
            $fell(RESET_I) |-> GATE_DATA_O == 4'h0 && HRDATA_O == 32'h0000_0000)
        else $error("outputs not cleared by reset");
    chk_idle_zero:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
            !rd_v |-> HRDATA_O == 32'h0000_0000)
        else $error("read data outside read");
    chk_sel_readback:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
            rd_v && ph_a < 32'h0000_0010 && ph_a[1:0] == 2'h0
            |-> HRDATA_O == {27'h000_0000, sh[ph_a[3:2]]})
        else $error("select read back wrong");
    chk_unmapped_zero:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
            rd_v && (ph_a > 32'h0000_0010 || ph_a[1:0] != 2'h0) |-> HRDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_upper_zero:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
            rd_v |-> HRDATA_O[31:5] == 27'h000_0000)
        else $error("upper read bits set");
    chk_sysclk_toggle:
        assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
            sh[0] == 5'h1F && $past(sh[0]) == 5'h1F && $past(sh[0], 2) == 5'h1F
            |-> GATE_DATA_O[0] != $past(GATE_DATA_O[0]))
        else $error("system clock source not toggling");
endmodule // lcis_props

bind lcis_top lcis_props u_props (.*);

//--- testbench/lcis_periph.sv
// Model of the peripheral and pin sources feeding the selection stage
module lcis_periph
(
    // Clock
    input  wire logic        clk_i,
    // Freeze sources
    input  wire logic        hold_i,
    // Candidates, codes 0 to 30
    output logic      [30:0] cand_o
);
    timeunit 1ns;
    timeprecision 100ps;
    integer seed = 82488;
    // Fresh pattern each cycle unless frozen
    always @(posedge clk_i)
        if (!hold_i)
            cand_o <= 31'($random(seed));
endmodule // lcis_periph

//--- testbench/lcis_test.sv
// Testbench of the cell input selection stage
module lcis_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        hold = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic [3:0]  m, exp_g, g1;
    wire  [31:0] hrdata;
    wire         hready, hresp;
    wire  [3:0]  gate;
    wire  [30:0] cand;
    integer      failures = 0;
    integer      checks = 0;
    int          sel_m [4];
    always #2 clk = ~clk;
    lcis_periph u_periph (.clk_i(clk), .hold_i(hold), .cand_o(cand));
    lcis_top DUT
    (
        .SYS_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .CELL_PIN_I(cand[3:0]), .LOGIC_CELL_OUT_I(cand[7:4]),
        .COMPARATOR_SYNC_OUT_I(cand[9:8]), .COMP_GEN_OUT_A_I(cand[10]),
        .COMP_GEN_OUT_B_I(cand[11]), .CAPTURE_COMPARE_OUT_I(cand[13:12]),
        .PULSE_WIDTH_OUT_I(cand[15:14]), .SYNC_SERIAL_CLK_I(cand[16]),
        .SYNC_SERIAL_DATA_I(cand[17]), .NUMERIC_OSC_OUTPUT_I(cand[18]),
        .ZERO_CROSS_OUTPUT_I(cand[19]), .ASYNC_SERIAL_TX_I(cand[20]),
        .ASYNC_SERIAL_DATA_I(cand[21]), .TIMER4_MATCH_I(cand[22]),
        .TIMER6_MATCH_I(cand[23]), .TIMER0_OVERFLOW_I(cand[24]),
        .TIMER1_OVERFLOW_I(cand[25]), .TIMER2_MATCH_I(cand[26]),
        .PIN_CHANGE_FLAG_I(cand[27]), .CONVERTER_RC_CLOCK_I(cand[28]),
        .LF_INTERNAL_OSC_I(cand[29]), .HF_INTERNAL_OSC_I(cand[30]),
        .GATE_DATA_O(gate)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Tasks
    task give_verdict;
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 32; c++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                sel_m[k] = (c + 9 * k) % 32;
                bus(1'b1, 32'(4 * k), 32'(sel_m[k]));
            end
            hold <= 1'b1;
            repeat (5) @(posedge clk);
            m = 4'h0;
            exp_g = 4'h0;
            for (int k = 0; k < 4; k++)
                if (sel_m[k] == 31)
                    m[k] = 1'b1;
                else
                    exp_g[k] = cand[sel_m[k]];
            cmp(32'(gate & ~m), 32'(exp_g));
            g1 = gate;
            @(posedge clk);
            cmp(32'((g1 ^ gate) & m), 32'(m));
            for (int k = 0; k < 4; k++)
            begin
                bus(1'b0, 32'(4 * k), 32'h0000_0000);
                cmp(rd, 32'(sel_m[k]));
            end
            bus(1'b0, 32'h0000_0010, 32'h0000_0000);
            cmp(rd & ~32'(m), 32'(exp_g));
            hold <= 1'b0;
        end
        bus(1'b1, 32'h0000_0000, 32'hFFFF_FFE5);
        bus(1'b1, 32'h0000_0014, 32'h0000_001F);
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        cmp(rd, 32'h0000_0005);
        bus(1'b0, 32'h0000_0014, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        bus(1'b0, 32'h0000_0100, 32'h0000_0000);
        cmp(rd, 32'h0000_0000);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b0, 32'(4 * k), 32'h0000_0000);
            cmp(rd, 32'h0000_0000);
        end
        give_verdict;
    end
    initial
    begin
        #100000;
        failures++;
        give_verdict;
    end
endmodule // lcis_test
